// ==== common/cie_regs.vh ====
`ifndef CIE_REGS_VH
`define CIE_REGS_VH

// Register port map, word index on reg_addr
`define CIE_REG_VBASE 2'h0
`define CIE_REG_STATUS 2'h1
`define CIE_REG_MODE 2'h2

// Status register bit positions
`define CIE_ST_LIVE 0
`define CIE_ST_SAVED 1
`define CIE_ST_PARITY 2
`define CIE_ST_EI_BLOCK 3
`define CIE_ST_NMI_PEND 4
`define CIE_ST_BUSY 5

// Reset values
`define CIE_RST_IFF 1'h0
`define CIE_RST_VBASE 8'h00
`define CIE_RST_MODE 2'h0

// Response modes
`define CIE_MODE0 2'h0
`define CIE_MODE1 2'h1
`define CIE_MODE2 2'h2

// Restart targets
`define CIE_NMI_VECTOR 16'h0066
`define CIE_MODE1_VECTOR 16'h0038

// Clock periods of each response phase
`define CIE_ACK_CLKS 5'h06
`define CIE_NFET_CLKS 5'h04
`define CIE_INTL_CLKS 5'h01
`define CIE_PUSH_CLKS 5'h06
`define CIE_TBL_CLKS 5'h06
`define CIE_BYTE_CLKS 5'h03
`define CIE_IO_REQUEST_STROBE_N_FROM 5'h02

`endif

// ==== tb/cie_irq_ctl_props.sv ====
module cie_props (
	input wire clk,
	input wire sys_rst,
	input wire instr_last,
	input wire enable_irq_instr,
	input wire disable_irq_instr,
	input wire return_from_nmi_instr,
	input wire load_acc_from_vector_base,
	input wire load_acc_from_refresh_reg,
	input wire opcode_fetch_cycle_n,
	input wire memory_request_strobe_n,
	input wire io_request_strobe_n,
	input wire irq_busy,
	input wire svc_go_q,
	input wire [15:0] svc_pc_q,
	input wire inject_go_q,
	input wire parity_flag_q,
	input wire live_irq_enable_q,
	input wire saved_irq_enable_q,
	input wire [1:0] irq_mode_q,
	input wire [7:0] vector_base_q
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	property p_rst;
		$fell(sys_rst) |-> !live_irq_enable_q && !saved_irq_enable_q
			&& irq_mode_q == 2'h0 && vector_base_q == 8'h00;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	// Acceptance outranks enable, so only idle cycles are judged
	property p_ei;
		enable_irq_instr && !instr_last && !irq_busy
			|=> live_irq_enable_q && saved_irq_enable_q;
	endproperty
	a_ei: assert property (p_ei) else $error("enable lost");
	property p_di;
		disable_irq_instr && !enable_irq_instr && !instr_last
			|=> !live_irq_enable_q && !saved_irq_enable_q;
	endproperty
	a_di: assert property (p_di) else $error("disable lost");
	// A response started while disabled must show no I/O ack in its first 6 cycles
	property p_mask;
		$rose(irq_busy) && !$past(live_irq_enable_q)
			|-> io_request_strobe_n [*6];
	endproperty
	a_mask: assert property (p_mask) else $error("masked ack");
	property p_ack;
		$fell(io_request_strobe_n) |-> (!io_request_strobe_n
			&& !opcode_fetch_cycle_n && memory_request_strobe_n) [*4]
			##1 io_request_strobe_n;
	endproperty
	a_ack: assert property (p_ack) else $error("ack shape");
	property p_len;
		$fell(io_request_strobe_n) && irq_mode_q == 2'h2 |-> ##17 svc_go_q;
	endproperty
	a_len: assert property (p_len) else $error("mode 2 length");
	// Only the non-maskable fetch starts with the memory strobe
	property p_nmi;
		$rose(irq_busy) && !memory_request_strobe_n |-> !live_irq_enable_q
			&& saved_irq_enable_q == $past(saved_irq_enable_q);
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi enables");
	property p_ld;
		load_acc_from_vector_base || load_acc_from_refresh_reg
			|=> parity_flag_q == $past(saved_irq_enable_q);
	endproperty
	a_ld: assert property (p_ld) else $error("parity copy");
	property p_return_from_nmi_instr;
		return_from_nmi_instr && !enable_irq_instr && !disable_irq_instr
			&& !instr_last |=> live_irq_enable_q == $past(saved_irq_enable_q)
			&& $stable(saved_irq_enable_q);
	endproperty
	a_return_from_nmi_instr: assert property (p_return_from_nmi_instr) else $error("nmi return");
	c_m2: cover property (svc_go_q && irq_mode_q == 2'h2);
	c_nmi: cover property (svc_go_q && svc_pc_q == 16'h0066);
	c_inj: cover property (inject_go_q);
endmodule

bind cie_irq_ctl cie_props i_props (.clk, .sys_rst, .instr_last,
	.enable_irq_instr, .disable_irq_instr, .return_from_nmi_instr,
	.load_acc_from_vector_base, .load_acc_from_refresh_reg,
	.opcode_fetch_cycle_n, .memory_request_strobe_n, .io_request_strobe_n,
	.irq_busy, .svc_go_q, .svc_pc_q, .inject_go_q, .parity_flag_q,
	.live_irq_enable_q, .saved_irq_enable_q, .irq_mode_q, .vector_base_q);

// ==== tb/cie_periph.sv ====
module cie_periph (
	input wire clk,
	input wire int_go,
	input wire nmi_go,
	input wire [7:0] vec,
	input wire [15:0] addr_out,
	input wire opcode_fetch_cycle_n,
	input wire io_request_strobe_n,
	input wire memory_request_strobe_n,
	input wire rd_n,
	output wire int_req_n,
	output wire nmi_req_n,
	output reg [7:0] data_in
);
	timeunit 1ns;
	timeprecision 1ns;
	reg [7:0] last_q = 8'h00;
	assign int_req_n = !int_go;
	assign nmi_req_n = !nmi_go;
	always @* begin
		if (!opcode_fetch_cycle_n && !io_request_strobe_n)
			data_in = vec;
		else if (!memory_request_strobe_n && !rd_n)
			data_in = addr_out[7:0] ^ addr_out[15:8];
		else
			// Released bus: no stale value to lean on
			data_in = ~last_q;
	end
	always @(posedge clk)
		last_q <= data_in;
endmodule

// ==== tb/tb_top.sv ====
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	reg clk = 1'b0;
	reg sys_rst = 1'b1;
	reg [5:0] ctl = 6'h00;
	reg set_mode_instr = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
	reg int_go = 1'b0, nmi_go = 1'b0;
	reg [1:0] set_mode_sel = 2'h0, reg_addr = 2'h0;
	reg [7:0] reg_wdata = 8'h00, d;
	reg [7:0] vec = 8'h3e;
	reg [15:0] n;
	wire int_req_n, nmi_req_n, opcode_fetch_cycle_n, memory_request_strobe_n;
	wire io_request_strobe_n, rd_n, irq_busy, svc_go_q, inject_go_q;
	wire parity_flag_q, live_irq_enable_q, saved_irq_enable_q;
	wire [15:0] addr_out, svc_pc_q;
	wire [7:0] data_in, inject_op_q, vector_base_q, reg_rdata_q;
	wire [1:0] irq_mode_q;
	int bad_count = 0;
	int n_tests = 0;
	always #50 clk = ~clk;
	// Tied: bus request, core registers and accumulator load path
	cie_irq_ctl i_dut (.clk, .sys_rst, .int_req_n, .nmi_req_n,
		.busreq_n(1'b1), .instr_last(ctl[5]), .enable_irq_instr(ctl[4]),
		.disable_irq_instr(ctl[3]), .return_from_nmi_instr(ctl[2]),
		.load_acc_from_vector_base(ctl[1]), .load_acc_from_refresh_reg(ctl[0]),
		.load_vector_base(1'b0), .acc_in(8'h00), .set_mode_instr,
		.set_mode_sel, .pc_in(16'h1234), .sp_in(16'h8000), .addr_out,
		.data_out(), .data_oe(), .data_in, .opcode_fetch_cycle_n,
		.memory_request_strobe_n, .io_request_strobe_n, .rd_n, .wr_n(),
		.irq_busy, .svc_go_q, .svc_pc_q, .sp_dec2_q(), .inject_go_q,
		.inject_op_q, .parity_flag_q, .live_irq_enable_q, .saved_irq_enable_q,
		.irq_mode_q, .vector_base_q, .reg_addr, .reg_wdata, .reg_we, .reg_re,
		.reg_rdata_q);
	cie_periph i_per (.clk, .int_go, .nmi_go, .vec, .addr_out,
		.opcode_fetch_cycle_n, .io_request_strobe_n, .memory_request_strobe_n,
		.rd_n, .int_req_n, .nmi_req_n, .data_in);
	task chk(input [15:0] seen, input [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Control pulses {last, en, dis, return_from_nmi_instr, ld_vb, ld_rf}, one cycle
	task step(input [5:0] c);
		@(posedge clk) ctl <= c;
		@(posedge clk) ctl <= 6'h00;
		#1;
	endtask
	task rb(input we, input [1:0] a, input [7:0] v);
		@(posedge clk) begin
			reg_we <= we;
			reg_re <= !we;
			reg_addr <= a;
			reg_wdata <= v;
		end
		@(posedge clk) begin
			reg_we <= 1'b0;
			reg_re <= 1'b0;
		end
		#1 d = reg_rdata_q;
	endtask
	task mode(input [1:0] m);
		@(posedge clk) begin
			set_mode_instr <= 1'b1;
			set_mode_sel <= m;
		end
		@(posedge clk) set_mode_instr <= 1'b0;
		#1;
	endtask
	// Bounded wait for the jump or the injected opcode
	task resp;
		step(6'h20);
		n = 16'h0000;
		while (n < 16'd40 && svc_go_q !== 1'b1 && inject_go_q !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask
	initial begin
		// Whole run is about 135 cycles
		#100000;
		bad_count++;
		end_sim;
	end
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk({live_irq_enable_q, saved_irq_enable_q}, 2'h0);
		chk(irq_mode_q, 2'h0);
		rb(1'b0, 2'h0, 8'h00);
		chk(d, 8'h00);
		rb(1'b1, 2'h0, 8'h71);
		rb(1'b0, 2'h0, 8'h00);
		chk(d, 8'h71);
		rb(1'b1, 2'h3, 8'h5c);
		rb(1'b0, 2'h3, 8'h00);
		chk(d, 8'h00);
		@(posedge clk) int_go <= 1'b1;
		repeat (3) @(posedge clk);
		step(6'h20);
		chk(irq_busy, 1'b0);
		mode(2'h2);
		chk(irq_mode_q, 2'h2);
		step(6'h30);
		chk(irq_busy, 1'b0);
		chk({live_irq_enable_q, saved_irq_enable_q}, 2'h3);
		resp;
		chk(n, 16'd19);
		chk(svc_pc_q, {8'h3f ^ 8'h71, 8'h3e ^ 8'h71});
		chk({live_irq_enable_q, saved_irq_enable_q}, 2'h0);
		for (int m = 1; m >= 0; m--) begin
			mode(m[1:0]);
			step(6'h30);
			resp;
			if (m == 1)
				chk(svc_pc_q, 16'h0038);
			else
				chk({inject_go_q, inject_op_q}, {1'b1, vec});
		end
		mode(2'h1);
		step(6'h30);
		@(posedge clk) nmi_go <= 1'b1;
		repeat (3) @(posedge clk);
		resp;
		chk(svc_pc_q, 16'h0066);
		chk({live_irq_enable_q, saved_irq_enable_q}, 2'h1);
		@(posedge clk) nmi_go <= 1'b0;
		step(6'h02);
		chk(parity_flag_q, 1'b1);
		step(6'h04);
		chk({live_irq_enable_q, saved_irq_enable_q}, 2'h3);
		step(6'h08);
		chk({live_irq_enable_q, saved_irq_enable_q}, 2'h0);
		step(6'h01);
		chk(parity_flag_q, 1'b0);
		step(6'h20);
		chk(irq_busy, 1'b0);
		// NMI taken with both enable flops clear
		@(posedge clk) nmi_go <= 1'b1;
		repeat (3) @(posedge clk);
		resp;
		chk(n, 16'd11);
		chk({live_irq_enable_q, saved_irq_enable_q}, 2'h0);
		@(posedge clk) nmi_go <= 1'b0;
		rb(1'b0, 2'h2, 8'h00);
		chk(d, 8'h01);
		end_sim;
	end
endmodule

// ==== verilog/cie_irq_ctl.v ====
// What this block does
// - Reset clears both live and saved enable flops.
// - Enable instruction sets both enable flops.
// - After enable, maskable accepted only after the following instruction ends.
// - Disable instruction clears both enable flops.
// - Live enable clear blocks every maskable request.
// - Accepting maskable clears both enable flops.
// - Accepting NMI clears live flop, saved flop kept.
// - Loads of vector base or refresh copy saved flop to parity.
// - Return from NMI copies saved flop into live flop.
// - NMI always accepted; fetch discarded, restart call to 0066H.
// - Three maskable response modes, exactly one active.
// - Mode 0 executes the instruction the peripheral drives.
// - Maskable acknowledge cycle carries two inserted wait states.
// - Reset selects response mode 0.
// - Mode 1 restarts at 0038H, acknowledge byte ignored.
// - Mode 2 pointer is vector base high, peripheral byte low.
// - Reset clears the vector base register.
// - Mode 2 reads two bytes, lower address is low half.
// - Mode 2 response takes 19 clock periods in total.
// - Requests sampled on the last clock of each instruction.
// - Maskable acknowledge is opcode fetch with I/O strobe, not memory.
// - NMI wins over maskable when both are pending.
//
// Decided for this implementation: the address map and strobed register access.
`include "cie_regs.vh"

module cie_irq_ctl (
	input wire clk,
	input wire sys_rst,
	input wire int_req_n,
	input wire nmi_req_n,
	input wire busreq_n,
	input wire instr_last,
	input wire enable_irq_instr,
	input wire disable_irq_instr,
	input wire return_from_nmi_instr,
	input wire load_acc_from_vector_base,
	input wire load_acc_from_refresh_reg,
	input wire load_vector_base,
	input wire [7:0] acc_in,
	input wire set_mode_instr,
	input wire [1:0] set_mode_sel,
	input wire [15:0] pc_in,
	input wire [15:0] sp_in,
	output wire [15:0] addr_out,
	output wire [7:0] data_out,
	output wire data_oe,
	input wire [7:0] data_in,
	output reg opcode_fetch_cycle_n,
	output reg memory_request_strobe_n,
	output reg io_request_strobe_n,
	output reg rd_n,
	output reg wr_n,
	output wire irq_busy,
	output reg svc_go_q,
	output reg [15:0] svc_pc_q,
	output reg sp_dec2_q,
	output reg inject_go_q,
	output reg [7:0] inject_op_q,
	output reg parity_flag_q,
	output reg live_irq_enable_q,
	output reg saved_irq_enable_q,
	output reg [1:0] irq_mode_q,
	output reg [7:0] vector_base_q,
	input wire [1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_we,
	input wire reg_re,
	output reg [7:0] reg_rdata_q
);

////////////////////////////////////////////////////////////////////////
localparam ST_IDLE = 3'h0;
localparam ST_ACK = 3'h1;
localparam ST_NFET = 3'h2;
localparam ST_INTL = 3'h3;
localparam ST_PUSH = 3'h4;
localparam ST_TBL = 3'h5;

reg [2:0] state_q;
reg [4:0] tcnt_q;
reg [15:0] addr_q;
reg [7:0] dout_q;
reg [7:0] vec_q;
reg [7:0] tgt_lo_q;
reg is_nmi_q;
reg [1:0] resp_mode_q;
reg ei_blk_q;
reg nmi_pend_q;
reg nmi_lvl_q;

////////////////////////////////////////////////////////////////////////
// Pin synchronisers; first stage feeds only the second
reg int_s1_q;
reg int_s2_q;
reg nmi_s1_q;
reg nmi_s2_q;
reg breq_s1_q;
reg breq_s2_q;

always @(posedge clk) begin
	if (sys_rst) begin
		int_s1_q <= 1'h1;
		int_s2_q <= 1'h1;
		nmi_s1_q <= 1'h1;
		nmi_s2_q <= 1'h1;
		breq_s1_q <= 1'h1;
		breq_s2_q <= 1'h1;
	end else begin
		int_s1_q <= int_req_n;
		int_s2_q <= int_s1_q;
		nmi_s1_q <= nmi_req_n;
		nmi_s2_q <= nmi_s1_q;
		breq_s1_q <= busreq_n;
		breq_s2_q <= breq_s1_q;
	end
end

////////////////////////////////////////////////////////////////////////
// Acceptance at instruction boundary
wire idle = (state_q == ST_IDLE);
wire nmi_fall = nmi_lvl_q & ~nmi_s2_q;
// No interrupts taken while the bus is granted away
wire at_end = instr_last & idle & breq_s2_q;
wire take_nmi = at_end & nmi_pend_q;
wire take_int = at_end & ~nmi_pend_q & ~int_s2_q
	& live_irq_enable_q
	& ~disable_irq_instr
	& ~enable_irq_instr & ~ei_blk_q;

assign irq_busy = ~idle;

// Falling edge latched so a short NMI pulse is never lost
always @(posedge clk) begin
	if (sys_rst) begin
		nmi_lvl_q <= 1'h1;
		nmi_pend_q <= 1'h0;
	end else begin
		nmi_lvl_q <= nmi_s2_q;
		if (nmi_fall)
			nmi_pend_q <= 1'h1;
		else if (take_nmi)
			nmi_pend_q <= 1'h0;
	end
end

// Shadow lasts only until the enable instruction ends
always @(posedge clk) begin
	if (sys_rst)
		ei_blk_q <= 1'h0;
	else if (enable_irq_instr & ~instr_last)
		ei_blk_q <= 1'h1;
	else if (instr_last)
		ei_blk_q <= 1'h0;
end

////////////////////////////////////////////////////////////////////////
// Enable flops, mode, vector base, parity copy
always @(posedge clk) begin
	if (sys_rst) begin
		live_irq_enable_q <= `CIE_RST_IFF;
		saved_irq_enable_q <= `CIE_RST_IFF;
	end else if (take_int) begin
		live_irq_enable_q <= 1'h0;
		saved_irq_enable_q <= 1'h0;
	end else if (take_nmi) begin
		live_irq_enable_q <= 1'h0;
	end else if (enable_irq_instr) begin
		live_irq_enable_q <= 1'h1;
		saved_irq_enable_q <= 1'h1;
	end else if (disable_irq_instr) begin
		live_irq_enable_q <= 1'h0;
		saved_irq_enable_q <= 1'h0;
	end else if (return_from_nmi_instr) begin
		live_irq_enable_q <= saved_irq_enable_q;
	end
end

always @(posedge clk) begin
	if (sys_rst)
		parity_flag_q <= 1'h0;
	else if (load_acc_from_vector_base | load_acc_from_refresh_reg)
		parity_flag_q <= saved_irq_enable_q;
end

// Code 3 is not a mode; the old mode stays
always @(posedge clk) begin
	if (sys_rst)
		irq_mode_q <= `CIE_RST_MODE;
	else if (set_mode_instr && set_mode_sel != 2'h3)
		irq_mode_q <= set_mode_sel;
end

always @(posedge clk) begin
	if (sys_rst)
		vector_base_q <= `CIE_RST_VBASE;
	else if (load_vector_base)
		vector_base_q <= acc_in;
	else if (reg_we && reg_addr == `CIE_REG_VBASE)
		vector_base_q <= reg_wdata;
end

////////////////////////////////////////////////////////////////////////
// Response sequencer
wire [4:0] ph = (tcnt_q >= `CIE_BYTE_CLKS) ?
	tcnt_q - `CIE_BYTE_CLKS : tcnt_q;
wire byte_end = (ph == `CIE_BYTE_CLKS - 5'h01);
wire [15:0] nmi_or_m1 = is_nmi_q ? `CIE_NMI_VECTOR
	: `CIE_MODE1_VECTOR;

always @(posedge clk) begin
	if (sys_rst) begin
		state_q <= ST_IDLE;
		tcnt_q <= 5'h00;
		addr_q <= 16'h0000;
		dout_q <= 8'h00;
		vec_q <= 8'h00;
		tgt_lo_q <= 8'h00;
		is_nmi_q <= 1'h0;
		resp_mode_q <= `CIE_RST_MODE;
		svc_go_q <= 1'h0;
		svc_pc_q <= 16'h0000;
		sp_dec2_q <= 1'h0;
		inject_go_q <= 1'h0;
		inject_op_q <= 8'h00;
	end else begin
		svc_go_q <= 1'h0;
		sp_dec2_q <= 1'h0;
		inject_go_q <= 1'h0;
		tcnt_q <= tcnt_q + 5'h01;
		case (state_q)
		ST_IDLE: begin
			tcnt_q <= 5'h00;
			addr_q <= pc_in;
			if (take_nmi) begin
				// Fetch runs but its opcode is dropped
				state_q <= ST_NFET;
				is_nmi_q <= 1'h1;
			end else if (take_int) begin
				state_q <= ST_ACK;
				is_nmi_q <= 1'h0;
				resp_mode_q <= irq_mode_q;
			end
		end
		ST_ACK: begin
			// Two waits let the daisy chain settle
			if (tcnt_q == `CIE_ACK_CLKS - 5'h01) begin
				tcnt_q <= 5'h00;
				vec_q <= data_in;
				if (resp_mode_q == `CIE_MODE0) begin
					inject_op_q <= data_in;
					inject_go_q <= 1'h1;
					state_q <= ST_IDLE;
				end else begin
					state_q <= ST_INTL;
				end
			end
		end
		ST_NFET: begin
			if (tcnt_q == `CIE_NFET_CLKS - 5'h01) begin
				tcnt_q <= 5'h00;
				state_q <= ST_INTL;
			end
		end
		ST_INTL: begin
			if (tcnt_q == `CIE_INTL_CLKS - 5'h01) begin
				tcnt_q <= 5'h00;
				state_q <= ST_PUSH;
				addr_q <= sp_in - 16'h0001;
				dout_q <= pc_in[15:8];
			end
		end
		ST_PUSH: begin
			if (tcnt_q == `CIE_PUSH_CLKS - 5'h01) begin
				tcnt_q <= 5'h00;
				sp_dec2_q <= 1'h1;
				if (!is_nmi_q && resp_mode_q == `CIE_MODE2) begin
					state_q <= ST_TBL;
					// Even pointer relies on the peripheral byte
					addr_q <= {vector_base_q, vec_q};
				end else begin
					state_q <= ST_IDLE;
					svc_go_q <= 1'h1;
					svc_pc_q <= nmi_or_m1;
				end
			end else if (byte_end) begin
				addr_q <= sp_in - 16'h0002;
				dout_q <= pc_in[7:0];
			end
		end
		ST_TBL: begin
			// 6 + 1 + 6 + 6 clocks for the whole response
			if (tcnt_q == `CIE_TBL_CLKS - 5'h01) begin
				tcnt_q <= 5'h00;
				state_q <= ST_IDLE;
				svc_go_q <= 1'h1;
				svc_pc_q <= {data_in, tgt_lo_q};
			end else if (byte_end) begin
				tgt_lo_q <= data_in;
				addr_q <= addr_q + 16'h0001;
			end
		end
		default: begin
			state_q <= ST_IDLE;
			tcnt_q <= 5'h00;
		end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////
// Bus strobes decoded from sequencer state
assign addr_out = addr_q;
assign data_out = dout_q;
assign data_oe = (state_q == ST_PUSH);

always @* begin
	opcode_fetch_cycle_n = 1'h1;
	memory_request_strobe_n = 1'h1;
	io_request_strobe_n = 1'h1;
	rd_n = 1'h1;
	wr_n = 1'h1;
	case (state_q)
	ST_ACK: begin
		// I/O strobe replaces the memory strobe
		opcode_fetch_cycle_n = 1'h0;
		if (tcnt_q >= `CIE_IO_REQUEST_STROBE_N_FROM)
			io_request_strobe_n = 1'h0;
	end
	ST_NFET: begin
		opcode_fetch_cycle_n = 1'h0;
		if (tcnt_q < `CIE_BYTE_CLKS - 5'h01) begin
			memory_request_strobe_n = 1'h0;
			rd_n = 1'h0;
		end
	end
	ST_PUSH: begin
		memory_request_strobe_n = 1'h0;
		if (ph == 5'h01)
			wr_n = 1'h0;
	end
	ST_TBL: begin
		memory_request_strobe_n = 1'h0;
		rd_n = 1'h0;
	end
	default: begin
		opcode_fetch_cycle_n = 1'h1;
	end
	endcase
end

////////////////////////////////////////////////////////////////////////
// Register port, read data one cycle after the strobe
always @(posedge clk) begin
	if (sys_rst) begin
		reg_rdata_q <= 8'h00;
	end else if (reg_re) begin
		case (reg_addr)
		`CIE_REG_VBASE: reg_rdata_q <= vector_base_q;
		`CIE_REG_STATUS: reg_rdata_q <= {2'h0, ~idle,
			nmi_pend_q, ei_blk_q, parity_flag_q,
			saved_irq_enable_q, live_irq_enable_q};
		`CIE_REG_MODE: reg_rdata_q <= {6'h00, irq_mode_q};
		default: reg_rdata_q <= 8'h00;
		endcase
	end else begin
		reg_rdata_q <= 8'h00;
	end
end

endmodule
